// ===== ctp_pkg.sv
/*
 * Constants, register map and types for the compact timer period control block.
 * Assumes an APB master on pclk and one counter-clock event input from outside.
 */
// Operation
// - With the run enable set and the pause bit clear the counter advances on its selected clock, with the run enable clear the counter stops and the timer is off.
// - A rise of the run enable clears the counter to zero before counting resumes.
// - A fall of the run enable holds the counter at its present value.
// - In compare-match-output mode a rise of the run enable forces the output pin to the initial level bit.
// - The three period bits are compared with counter bits 9 to 7 only, so matches fall on multiples of 128 clocks.
// - Period code 001 to 111 gives 128 to 896 clocks in steps of 128, and 000 gives 1024 clocks.
// - With the clear select bit at 0 a period match clears the counter.
// - A period code of zero gives no early match, so the counter runs to its maximum and overflows.
// - The counter is a 10-bit up-counter that also clears on overflow or on the match chosen by the clear select bit, each raising an interrupt request.
// - The two mode bits select 00 compare-match output, 01 undefined, 10 PWM, 11 timer/counter.
package ctp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] ADDR_CTRL0  = 12'h000;
    localparam logic [11:0] ADDR_CTRL1  = 12'h004;
    localparam logic [11:0] ADDR_COUNT  = 12'h008;
    localparam logic [11:0] ADDR_MATCHA = 12'h00c;
    localparam logic [11:0] ADDR_ISTAT  = 12'h010;
    localparam logic [11:0] ADDR_IEN    = 12'h014;
    localparam logic [11:0] ADDR_ICLR   = 12'h018;

    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;

    localparam int CNT_W  = 10;
    localparam int PER_W  = 3;
    localparam int PER_LO = 7;
    localparam int EVT_W  = 3;

    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
    localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3ff;
    localparam logic [PER_W-1:0] PER_NONE = 3'h0;

    // Interrupt event bits
    localparam int EVT_OVF = 0;
    localparam int EVT_PER = 1;
    localparam int EVT_MA  = 2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_CMP   = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM   = 2'b10,
        MODE_TMR   = 2'b11
    } ctp_mode_e;

    typedef struct packed {
        logic             pause;
        logic [2:0]       clk_sel;
        logic             counter_run_enable;
        logic [PER_W-1:0] period_compare_bits;
    } ctp_ctrl0_s;

    typedef struct packed {
        logic       mode_select_hi;
        logic       mode_select_lo;
        logic       output_function_hi;
        logic       output_function_lo;
        logic       output_initial_level;
        logic       output_polarity;
        logic       duty_period_swap;
        logic       counter_clear_select;
    } ctp_ctrl1_s;

endpackage

// ===== ctp_timer.sv
/*
 * Compact timer: run control, 10-bit counter, period and match A comparators,
 * compare-match output pin and a sticky interrupt block, all behind APB.
 * Assumes cnt_tick is a one-cycle pulse per selected counter-clock edge, made outside.
 */
`timescale 1ns/100ps
`default_nettype none

module ctp_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cnt_tick,
    output logic             timer_out,
    output logic             timer_out_oe_n,
    output logic             irq
);

    // ****************************************
    // State
    // ****************************************
    ctp_pkg::ctp_ctrl0_s          ctrl0_reg;
    ctp_pkg::ctp_ctrl1_s          ctrl1_reg;
    logic [ctp_pkg::CNT_W-1:0]    count_reg;
    logic [ctp_pkg::CNT_W-1:0]    count_next;
    logic [ctp_pkg::CNT_W-1:0]    match_a_value_reg;
    logic                         pin_reg;
    logic                         pin_next;
    logic [ctp_pkg::EVT_W-1:0]    istat_reg;
    logic [ctp_pkg::EVT_W-1:0]    ien_reg;
    logic [31:0]                  prdata_reg;
    logic                         pready_reg;
    logic                         pslverr_reg;
    logic                         irq_reg;

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic        setup_rd  = psel && !penable && !pwrite;
    wire logic        acc_wr    = psel && penable && pwrite && pready_reg;
    wire logic        hit_c0    = (paddr == ctp_pkg::ADDR_CTRL0);
    wire logic        hit_c1    = (paddr == ctp_pkg::ADDR_CTRL1);
    wire logic        hit_cnt   = (paddr == ctp_pkg::ADDR_COUNT);
    wire logic        hit_ma    = (paddr == ctp_pkg::ADDR_MATCHA);
    wire logic        hit_is    = (paddr == ctp_pkg::ADDR_ISTAT);
    wire logic        hit_ie    = (paddr == ctp_pkg::ADDR_IEN);
    wire logic        hit_ic    = (paddr == ctp_pkg::ADDR_ICLR);
    wire logic        hit_any   = hit_c0 || hit_c1 || hit_cnt || hit_ma || hit_is || hit_ie || hit_ic;
    wire logic        wr_c0     = acc_wr && hit_c0;
    wire logic        wr_c1     = acc_wr && hit_c1;
    wire logic        wr_ma     = acc_wr && hit_ma;
    wire logic        wr_ie     = acc_wr && hit_ie;
    wire logic        wr_ic     = acc_wr && hit_ic;
    wire logic [31:0] rd_mux;

    assign rd_mux = hit_c0  ? {24'h00_0000, ctrl0_reg} :
                    hit_c1  ? {24'h00_0000, ctrl1_reg} :
                    hit_cnt ? {22'h00_0000, count_reg} :
                    hit_ma  ? {22'h00_0000, match_a_value_reg} :
                    hit_is  ? {29'h0000_0000, istat_reg} :
                    hit_ie  ? {29'h0000_0000, ien_reg} :
                    32'h0000_0000;

    // ****************************************
    // Run control and comparators
    // ****************************************
    ctp_pkg::ctp_ctrl0_s wdat0;
    assign wdat0 = pwdata[7:0];

    wire logic run       = ctrl0_reg.counter_run_enable;
    wire logic run_rise  = wr_c0 && wdat0.counter_run_enable && !run;
    wire logic ticking   = run && !ctrl0_reg.pause && cnt_tick;
    wire logic [1:0] mode = {ctrl1_reg.mode_select_hi, ctrl1_reg.mode_select_lo};
    wire logic cmp_mode  = (mode == ctp_pkg::MODE_CMP);
    wire logic pwm_mode  = (mode == ctp_pkg::MODE_PWM);

    wire logic [ctp_pkg::CNT_W-1:0] count_inc = count_reg + ctp_pkg::CNT_ONE;

    // Compared on the incremented value so the clear lands after exactly N clocks
    wire logic per_hit  = ticking && (ctrl0_reg.period_compare_bits != ctp_pkg::PER_NONE)
                          && (count_inc[ctp_pkg::CNT_W-1:ctp_pkg::PER_LO]
                              == ctrl0_reg.period_compare_bits);
    wire logic ovf_hit  = ticking && (count_reg == ctp_pkg::CNT_MAX);
    wire logic ma_hit   = ticking && (count_inc == match_a_value_reg);
    wire logic clr_per  = per_hit && !ctrl1_reg.counter_clear_select;
    wire logic clr_ma   = ma_hit && ctrl1_reg.counter_clear_select;

    // Match A drives the output pin; undefined mode leaves it alone
    wire logic [1:0] ofn = {ctrl1_reg.output_function_hi, ctrl1_reg.output_function_lo};
    wire logic [ctp_pkg::EVT_W-1:0] evt;
    assign evt = {ma_hit, per_hit, ovf_hit};

    always_comb begin
        count_next = count_reg;
        if (run_rise) begin
            count_next = ctp_pkg::CNT_ZERO;
        end else if (ticking) begin
            if (clr_per || clr_ma) begin
                count_next = ctp_pkg::CNT_ZERO;
            end else begin
                count_next = count_inc;
            end
        end
        // Holding when run is low keeps the residual value for software to read
    end

    always_comb begin
        pin_next = pin_reg;
        if (run_rise && cmp_mode) begin
            pin_next = wdat0.counter_run_enable ? ctrl1_reg.output_initial_level : pin_reg;
        end else if (ma_hit && cmp_mode) begin
            case (ofn)
                2'b01:   pin_next = 1'b0;
                2'b10:   pin_next = 1'b1;
                2'b11:   pin_next = !pin_reg;
                default: pin_next = pin_reg;
            endcase
        end else if (pwm_mode && ticking) begin
            pin_next = (count_inc < match_a_value_reg);
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg         <= ctp_pkg::CTRL0_RESET;
            ctrl1_reg         <= ctp_pkg::CTRL1_RESET;
            match_a_value_reg <= ctp_pkg::CNT_ZERO;
            ien_reg           <= '0;
        end else begin
            if (wr_c0) begin
                ctrl0_reg <= wdat0;
            end
            if (wr_c1) begin
                ctrl1_reg <= pwdata[7:0];
            end
            if (wr_ma) begin
                match_a_value_reg <= pwdata[ctp_pkg::CNT_W-1:0];
            end
            if (wr_ie) begin
                ien_reg <= pwdata[ctp_pkg::EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= ctp_pkg::CNT_ZERO;
            pin_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            pin_reg   <= pin_next;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= '0;
        end else begin
            istat_reg <= (istat_reg & ~(wr_ic ? pwdata[ctp_pkg::EVT_W-1:0] : '0)) | evt;
        end
    end

    // One wait state: read data is registered during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            pready_reg  <= psel && !pready_reg && !(penable && pready_reg) && penable;
            pslverr_reg <= psel && penable && !pready_reg && !hit_any;
            if (setup_rd) begin
                prdata_reg <= rd_mux;
            end
            irq_reg     <= |(((istat_reg & ~(wr_ic ? pwdata[ctp_pkg::EVT_W-1:0] : '0)) | evt)
                             & ien_reg);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign timer_out      = ctrl1_reg.output_polarity ? !pin_reg : pin_reg;
    assign timer_out_oe_n = !run || (mode == ctp_pkg::MODE_TMR) || (mode == ctp_pkg::MODE_UNDEF);
    assign irq            = irq_reg;

endmodule

`default_nettype wire

// ===== ctp_timer_checker.sv
/* Port checker for ctp_timer: bus answer timing, refusals and pin release.
   Assumes it is bound to every ctp_timer instance and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module ctp_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cnt_tick,
    input wire logic        timer_out,
    input wire logic        timer_out_oe_n,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Sequences and properties
    // ****************************************
    sequence s_read_done;
        pready && !pslverr && !pwrite;
    endsequence
    sequence s_mask_all;
        pready && pwrite && paddr == ctp_pkg::ADDR_IEN && pwdata[2:0] == 3'h0;
    endsequence
    property p_answer;
        psel && $rose(penable) |=> pready;
    endproperty
    property p_one_cycle;
        pready |=> !pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_err_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
    endproperty
    property p_count_width;
        s_read_done and (paddr == ctp_pkg::ADDR_COUNT) |-> prdata[31:10] == 22'h00_0000;
    endproperty
    property p_off_released;
        s_read_done and (paddr == ctp_pkg::ADDR_CTRL0 && !prdata[3]) |-> timer_out_oe_n;
    endproperty
    property p_tmr_released;
        s_read_done and (paddr == ctp_pkg::ADDR_CTRL1 && prdata[7:6] == 2'b11) |-> timer_out_oe_n;
    endproperty
    // Irq is registered, so a mask takes one extra cycle to show
    property p_irq_masked;
        s_mask_all |=> ##1 !irq;
    endproperty
    a_answer: assert property (p_answer) else $error("late bus answer");
    a_one_cycle: assert property (p_one_cycle) else $error("ready too long");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    a_count_width: assert property (p_count_width) else $error("count too wide");
    a_off_released: assert property (p_off_released) else $error("pin driven when off");
    a_tmr_released: assert property (p_tmr_released) else $error("pin driven in timer");
    a_irq_masked: assert property (p_irq_masked) else $error("irq not masked");
endmodule
bind ctp_timer ctp_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_tick(cnt_tick), .timer_out(timer_out),
    .timer_out_oe_n(timer_out_oe_n), .irq(irq));
`default_nettype wire

// ===== tb.sv
/* Self-checking bench for ctp_timer: registers, run control, period, pin, interrupts.
   Assumes ctp_pkg, ctp_timer and the checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        cnt_tick = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, timer_out, timer_out_oe_n, irq;
    logic [31:0] rd;
    logic        err;
    int          fails = 0;
    int          checked = 0;
    int          cycles = 0;
    always #4 pclk = ~pclk;
    ctp_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cnt_tick(cnt_tick), .timer_out(timer_out),
        .timer_out_oe_n(timer_out_oe_n), .irq(irq));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Request held until the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, e);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            cnt_tick <= 1'b1;
            @(posedge pclk);
            cnt_tick <= 1'b0;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rdchk(ctp_pkg::ADDR_CTRL0, 32'h0000_0000);
        apb(1'b1, ctp_pkg::ADDR_CTRL1, 8'hc0);
        rdchk(ctp_pkg::ADDR_CTRL1, 32'h0000_00c0);
        apb(1'b1, ctp_pkg::ADDR_CTRL1, 8'h00);
        rdchk(12'h01c, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
    endtask
    task automatic t_run;
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h08);
        tick(5);
        rdchk(ctp_pkg::ADDR_COUNT, 32'h0000_0005);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
        tick(3);
        rdchk(ctp_pkg::ADDR_COUNT, 32'h0000_0005);
        check({31'h0000_0000, timer_out_oe_n}, 32'h0000_0001);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h08);
        rdchk(ctp_pkg::ADDR_COUNT, 32'h0000_0000);
    endtask
    // Every code, zero included: the count just short of the period must survive
    task automatic t_period;
        int n;
        for (int c = 0; c < 8; c++) begin
            n = (c == 0) ? 1024 : c * 128;
            apb(1'b1, ctp_pkg::ADDR_ICLR, 8'h07);
            apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
            apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'(8 + c));
            tick(n - 1);
            rdchk(ctp_pkg::ADDR_COUNT, 32'(n - 1));
            tick(1);
            rdchk(ctp_pkg::ADDR_COUNT, 32'h0000_0000);
            apb(1'b0, ctp_pkg::ADDR_ISTAT, 8'h00);
            check({30'h0000_0000, rd[1:0]}, (c == 0) ? 32'h0000_0001 : 32'h0000_0002);
        end
    endtask
    task automatic t_pin;
        for (int lv = 1; lv >= 0; lv--) begin
            apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
            apb(1'b1, ctp_pkg::ADDR_CTRL1, 8'(lv * 8));
            apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h08);
            @(negedge pclk);
            check({31'h0000_0000, timer_out}, 32'(lv));
            check({31'h0000_0000, timer_out_oe_n}, 32'h0000_0000);
        end
    endtask
    task automatic t_irq;
        apb(1'b1, ctp_pkg::ADDR_ICLR, 8'h07);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h09);
        tick(128);
        repeat (2) @(negedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        apb(1'b1, ctp_pkg::ADDR_IEN, 8'h02);
        repeat (2) @(negedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        apb(1'b1, ctp_pkg::ADDR_IEN, 8'h00);
        apb(1'b1, ctp_pkg::ADDR_IEN, 8'h02);
        apb(1'b1, ctp_pkg::ADDR_ICLR, 8'h02);
        repeat (2) @(negedge pclk);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        rdchk(ctp_pkg::ADDR_ISTAT, 32'h0000_0000);
    endtask
    // Match A clear and toggle, pause, then PWM level against match A
    task automatic t_match;
        apb(1'b1, ctp_pkg::ADDR_ICLR, 8'h07);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
        apb(1'b1, ctp_pkg::ADDR_CTRL1, 8'h31);
        apb(1'b1, ctp_pkg::ADDR_MATCHA, 8'h03);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h08);
        tick(3);
        @(negedge pclk);
        check({31'h0000_0000, timer_out}, 32'h0000_0001);
        rdchk(ctp_pkg::ADDR_COUNT, 32'h0000_0000);
        apb(1'b0, ctp_pkg::ADDR_ISTAT, 8'h00);
        check({31'h0000_0000, rd[2]}, 32'h0000_0001);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h88);
        tick(2);
        rdchk(ctp_pkg::ADDR_COUNT, 32'h0000_0000);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
        apb(1'b1, ctp_pkg::ADDR_CTRL1, 8'h80);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h08);
        tick(3);
        @(negedge pclk);
        check({31'h0000_0000, timer_out}, 32'h0000_0000);
        check({31'h0000_0000, timer_out_oe_n}, 32'h0000_0000);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h08);
        tick(1);
        @(negedge pclk);
        check({31'h0000_0000, timer_out}, 32'h0000_0001);
        apb(1'b1, ctp_pkg::ADDR_CTRL0, 8'h00);
        apb(1'b1, ctp_pkg::ADDR_CTRL1, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_run();
        t_period();
        t_pin();
        t_irq();
        t_match();
        end_sim();
    end
    // Whole run is about 10000 cycles; the ceiling leaves ample margin
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            end_sim();
        end
    end
endmodule
`default_nettype wire
